/* rtl/arbop_reg_bank.sv */
// Overview of operation
// - Port write latches the terminal drive byte
// - Terminals drive only where configured as output
// - Word write to port uses low byte
// - Latched value survives switching pin to input
// - Bit command sets or clears one terminal
// - Wait request held low while settling
// - Every axis has its own register set
// - Profile registers, each pre-registered
// - Interpolation centre and S-curve ranges, pre-registered
// - Correction speed register, no pre-register
// - Seven environment registers, fifth narrower
// - Four counters plus read-only latch copies
// - Comparators one to four, no pre-register
// - Comparator five data with own pre-register
// - Nineteen-bit event interrupt select register
// - Read-only residual pulse positioning counter
// - Read-only zero count and speed monitor
// - Read-only automatic ramp-down point
// - Interpolation step count with pre-register
// - Read-only circular step counter
// - Reset clears all registers and pre-registers
// - Read command fills buffer within four clocks
// - Two-deep queue advances on completion
`timescale 1ns/1ps
`include "arbop_consts.svh"

module arbop_reg_bank #(
    parameter int NUM_AXES = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Host bus
    input wire arbop_pkg::arbop_bus_type bus,
    output logic [15:0] bus_rdata,
    output logic wait_request_n,
    // Motion core side
    input wire logic [NUM_AXES-1:0] op_done,
    input wire logic [NUM_AXES-1:0] cmp5_match,
    input wire arbop_pkg::arbop_monitor_type [NUM_AXES-1:0] monitor,
    output logic [NUM_AXES-1:0][31:0][31:0] axis_work,
    output logic [NUM_AXES-1:0][1:0] op_queue_fill,
    output logic [NUM_AXES-1:0][1:0] cmp_queue_fill,
    // General-purpose terminals
    output logic [7:0] gp_port_terminals_o,
    output logic [7:0] gp_port_terminals_oe
);

    typedef struct packed {
        logic [NUM_AXES-1:0][31:0][31:0] work;
        logic [NUM_AXES-1:0][`ARBOP_PRE_SLOTS-1:0][31:0] pre1;
        logic [NUM_AXES-1:0][`ARBOP_PRE_SLOTS-1:0][31:0] pre2;
        logic [NUM_AXES-1:0][1:0] fill;
        logic [NUM_AXES-1:0][1:0] cfill;

        logic [7:0] axis_sel;
        logic [31:0] io_buf;

        arbop_pkg::arbop_settle_type fsm;
        logic [2:0] settle_cnt;
        logic [15:0] rdata;
        logic wait_n;
    } arbop_bank_state_type;

    arbop_bank_state_type st;
    arbop_bank_state_type next_st;

    // Register width by index; zero means none
    function automatic logic [5:0] reg_width(input logic [5:0] idx);
        logic [5:0] w;
        w = 6'd0;
        case (idx)
            6'h00, 6'h07, 6'h08: w = 6'd28;
            6'h01, 6'h02, 6'h03, 6'h04: w = 6'd16;
            6'h05: w = 6'd12;
            6'h06: w = 6'd24;
            6'h09, 6'h0a: w = 6'd15;
            6'h0b: w = 6'd16;

            6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h11, 6'h12: w = 6'd32;
            6'h10: w = 6'd28;

            6'h13, 6'h14, 6'h16: w = 6'd28;
            6'h15: w = 6'd16;

            6'h17, 6'h18, 6'h19, 6'h1a, 6'h1b: w = 6'd28;

            6'h1c: w = 6'd19;

            6'h2c: w = 6'd24;
            default: w = 6'd0;
        endcase
        return w;
    endfunction : reg_width

    // Mask of the implemented bits of a writable register
    function automatic logic [31:0] reg_mask(input logic [5:0] idx);
        logic [5:0] w;
        w = reg_width(idx);
        return (w == 6'd0) ? 32'h0000_0000 : (32'hffff_ffff >> (6'd32 - w));
    endfunction : reg_mask

    // Storage slot of a writable register
    function automatic logic [4:0] work_slot(input logic [5:0] idx);
        return (idx == `ARBOP_IDX_STEPS) ? `ARBOP_SLOT_STEPS : idx[4:0];
    endfunction : work_slot

    // Register index that an operation pre-register slot feeds; the comparator slot returns its own number
    function automatic logic [5:0] pre_index(input logic [3:0] p);
        return (p == `ARBOP_PRE_STEPS) ? `ARBOP_IDX_STEPS : {2'h0, p};
    endfunction : pre_index

    // Operation pre-register slots, not the comparator
    function automatic logic is_op_slot(input logic [3:0] p);
        return (p <= `ARBOP_PRE_LAST_OP) || (p == `ARBOP_PRE_STEPS);
    endfunction : is_op_slot

    logic [7:0] cmd_code;
    logic [7:0] sel_now;
    logic cmd_exec;
    logic port_wr;
    logic bit_wr;

    logic [5:0] rd_idx;
    logic [5:0] wr_idx;
    logic [3:0] pre_idx;

    logic [31:0] rd_value [NUM_AXES];

    // Decode of the host cycle; command and port writes while settling are not taken
    always_comb begin
        cmd_code = bus.wdata[7:0];
        sel_now = bus.word_mode ? bus.wdata[15:8] : st.axis_sel;

        cmd_exec = bus.wr && (st.fsm == arbop_pkg::ARBOP_IDLE) && (bus.addr == `ARBOP_ADDR_CMD);
        port_wr = bus.wr && (st.fsm == arbop_pkg::ARBOP_IDLE) && (bus.addr == `ARBOP_ADDR_PORT);
        bit_wr = cmd_exec
            && ((cmd_code[7:3] == `ARBOP_CMD_BIT_SET) || (cmd_code[7:3] == `ARBOP_CMD_BIT_CLR));

        rd_idx = 6'(cmd_code - `ARBOP_CMD_RD);
        wr_idx = 6'(cmd_code - `ARBOP_CMD_WR);
        pre_idx = 4'(cmd_code - `ARBOP_CMD_PRE_WR);
        if (cmd_code >= `ARBOP_CMD_PRE_RD && cmd_code <= `ARBOP_CMD_PRE_RD_LAST) begin
            pre_idx = 4'(cmd_code - `ARBOP_CMD_PRE_RD);
        end
    end

    // Read-back value of each axis
    generate
        for (genvar a = 0; a < NUM_AXES; a++) begin : g_read
            always_comb begin
                rd_value[a] = 32'h0000_0000;
                if (rd_idx <= `ARBOP_IDX_LAST_RW || rd_idx == `ARBOP_IDX_STEPS) begin
                    rd_value[a] = st.work[a][work_slot(rd_idx)] & reg_mask(rd_idx);

                end else if (rd_idx == 6'h1d) begin
                    rd_value[a] = 32'(monitor[a].cmd_pos_latch);
                end else if (rd_idx == 6'h1e) begin
                    rd_value[a] = 32'(monitor[a].mech_pos_latch);
                end else if (rd_idx == 6'h1f) begin
                    rd_value[a] = 32'(monitor[a].deflection_latch);
                end else if (rd_idx == 6'h20) begin
                    rd_value[a] = 32'(monitor[a].gp_latch);

                end else if (rd_idx == 6'h21) begin
                    rd_value[a] = 32'(monitor[a].extension_status);
                end else if (rd_idx == 6'h22) begin
                    rd_value[a] = 32'(monitor[a].error_irq_status);
                end else if (rd_idx == 6'h23) begin
                    rd_value[a] = 32'(monitor[a].event_irq_status);

                end else if (rd_idx == 6'h24) begin
                    rd_value[a] = 32'(monitor[a].residual_pulse_count);
                end else if (rd_idx == 6'h25) begin
                    rd_value[a] = 32'(monitor[a].zero_count_speed_monitor);
                end else if (rd_idx == 6'h26) begin
                    rd_value[a] = 32'(monitor[a].auto_rampdown_point);
                end else if (rd_idx == 6'h2d) begin
                    rd_value[a] = 32'(monitor[a].circular_step_counter);
                end else if (rd_idx == 6'h2f) begin
                    rd_value[a] = 32'(monitor[a].interp_status);
                end
            end
        end
    endgenerate

    // Next state: queue events first, the host command overrides them
    always_comb begin
        logic rd_done;
        next_st = st;
        rd_done = 1'b0;

        // Host reads; rdata stands until the next read
        if (bus.rd) begin
            if (bus.addr == `ARBOP_ADDR_CMD) begin
                next_st.rdata = {12'h000, st.cfill[0], st.fill[0]};
            end else if (bus.addr[2] && bus.word_mode) begin
                next_st.rdata = bus.addr[1] ? st.io_buf[31:16] : st.io_buf[15:0];
            end else if (bus.addr[2]) begin
                next_st.rdata = {8'h00, st.io_buf[8*bus.addr[1:0] +: 8]};
            end else begin
                next_st.rdata = 16'h0000;
            end
        end

        // Buffer and axis select writes need no settling
        if (bus.wr && bus.addr[2]) begin
            if (bus.word_mode) begin
                next_st.io_buf[16*bus.addr[1] +: 16] = bus.wdata;
            end else begin
                next_st.io_buf[8*bus.addr[1:0] +: 8] = bus.wdata[7:0];
            end
        end

        if (bus.wr && !bus.word_mode && bus.addr == `ARBOP_ADDR_AXIS) begin
            next_st.axis_sel = bus.wdata[7:0];
        end

        if (cmd_exec && bus.word_mode) begin
            next_st.axis_sel = bus.wdata[15:8];
        end

        // Settling window after a command or port write
        if (st.fsm == arbop_pkg::ARBOP_SETTLE) begin
            if (st.settle_cnt == 3'h0) begin
                next_st.fsm = arbop_pkg::ARBOP_IDLE;
                next_st.wait_n = 1'b1;
            end else begin
                next_st.settle_cnt = st.settle_cnt - 3'h1;
            end
        end else if (cmd_exec || port_wr) begin
            next_st.fsm = arbop_pkg::ARBOP_SETTLE;
            next_st.settle_cnt = `ARBOP_SETTLE_CYCLES - 3'h1;
            next_st.wait_n = 1'b0;
        end

        for (int a = 0; a < NUM_AXES; a++) begin
            // Completion of the running operation pulls the queue forward
            if (op_done[a] && st.fill[a] != 2'h0) begin
                if (st.fill[a] >= 2'h2) begin
                    for (int p = 0; p < `ARBOP_PRE_SLOTS; p++) begin
                        if (is_op_slot(4'(p))) begin
                            next_st.work[a][work_slot(pre_index(4'(p)))] = st.pre1[a][p];
                            next_st.pre1[a][p] = st.pre2[a][p];
                        end
                    end
                end
                next_st.fill[a] = st.fill[a] - 2'h1;
            end

            // Comparator five shifts in each cycle that its match input is high and at least two entries are queued
            if (cmp5_match[a] && st.cfill[a] >= 2'h2) begin
                next_st.work[a][`ARBOP_IDX_CMP5] = st.pre1[a][`ARBOP_PRE_CMP];
                next_st.pre1[a][`ARBOP_PRE_CMP] = st.pre2[a][`ARBOP_PRE_CMP];
                next_st.cfill[a] = st.cfill[a] - 2'h1;
            end

            if (cmd_exec && sel_now[a]) begin
                if (cmd_code >= `ARBOP_CMD_WR && cmd_code <= `ARBOP_CMD_WR_LAST) begin
                    if (wr_idx <= `ARBOP_IDX_LAST_RW || wr_idx == `ARBOP_IDX_STEPS) begin
                        next_st.work[a][work_slot(wr_idx)] = st.io_buf & reg_mask(wr_idx);
                    end

                end else if (cmd_code >= `ARBOP_CMD_PRE_WR && cmd_code <= `ARBOP_CMD_PRE_WR_LAST) begin
                    next_st.pre2[a][pre_idx] = st.io_buf & reg_mask(pre_index(pre_idx));
                    if (pre_idx == `ARBOP_PRE_CMP) begin
                        // Comparator data is committed by the write itself
                        if (st.cfill[a] == 2'h0) begin
                            next_st.work[a][`ARBOP_IDX_CMP5] = st.io_buf & reg_mask(`ARBOP_IDX_CMP5);
                        end else if (st.cfill[a] == 2'h1) begin
                            next_st.pre1[a][`ARBOP_PRE_CMP] = st.io_buf & reg_mask(`ARBOP_IDX_CMP5);
                        end
                        if (st.cfill[a] != 2'h3) begin
                            next_st.cfill[a] = st.cfill[a] + 2'h1;
                        end
                    end

                end else if (cmd_code == `ARBOP_CMD_START) begin
                    // A start commits the writable layer to the first free level, work at fill 0 and pre1 at fill 1; a full queue ignores it
                    for (int p = 0; p < `ARBOP_PRE_SLOTS; p++) begin
                        if (is_op_slot(4'(p)) && st.fill[a] == 2'h0) begin
                            next_st.work[a][work_slot(pre_index(4'(p)))] = st.pre2[a][p];
                        end else if (is_op_slot(4'(p)) && st.fill[a] == 2'h1) begin
                            next_st.pre1[a][p] = st.pre2[a][p];
                        end
                    end
                    if (st.fill[a] != 2'h3) begin
                        next_st.fill[a] = st.fill[a] + 2'h1;
                    end

                end else if (cmd_code == `ARBOP_CMD_OP_CANCEL) begin
                    next_st.fill[a] = (st.fill[a] != 2'h0) ? 2'h1 : 2'h0;
                end else if (cmd_code == `ARBOP_CMD_CMP_CANCEL) begin
                    next_st.cfill[a] = (st.cfill[a] != 2'h0) ? 2'h1 : 2'h0;

                end else if (!rd_done && cmd_code >= `ARBOP_CMD_PRE_RD && cmd_code <= `ARBOP_CMD_PRE_RD_LAST) begin
                    next_st.io_buf = st.pre2[a][pre_idx];
                    rd_done = 1'b1;
                end else if (!rd_done && cmd_code >= `ARBOP_CMD_RD) begin
                    next_st.io_buf = rd_value[a];
                    rd_done = 1'b1;
                end
            end
        end
    end

    // State register; every register and pre-register clears to zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.fsm <= arbop_pkg::ARBOP_IDLE;
            st.wait_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Output port; a word write keeps only its low byte
    arbop_out_port u_out_port (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .byte_wr(port_wr),
        .byte_data(bus.wdata[7:0]),
        .bit_wr(bit_wr),
        .bit_sel(cmd_code[2:0]),
        .bit_val(cmd_code[4]),
        .dir_out(st.work[0][`ARBOP_IDX_PORT_CFG][7:0]),
        .gp_port_terminals_o(gp_port_terminals_o),
        .gp_port_terminals_oe(gp_port_terminals_oe)
    );

    assign bus_rdata = st.rdata;
    assign wait_request_n = st.wait_n;
    assign axis_work = st.work;
    assign op_queue_fill = st.fill;
    assign cmp_queue_fill = st.cfill;

endmodule : arbop_reg_bank

/* rtl/arbop_consts.svh */
`ifndef ARBOP_CONSTS_SVH
`define ARBOP_CONSTS_SVH

// Byte addresses on the host bus, which carries bytes or 16-bit words
`define ARBOP_ADDR_CMD 3'h0
`define ARBOP_ADDR_AXIS 3'h1
`define ARBOP_ADDR_PORT 3'h2
`define ARBOP_ADDR_BUF 3'h4

// Command code ranges
`define ARBOP_CMD_PRE_WR 8'h80
`define ARBOP_CMD_PRE_WR_LAST 8'h8c
`define ARBOP_CMD_WR 8'h90
`define ARBOP_CMD_WR_LAST 8'hbf
`define ARBOP_CMD_PRE_RD 8'hc0
`define ARBOP_CMD_PRE_RD_LAST 8'hcc
`define ARBOP_CMD_RD 8'hd0
`define ARBOP_CMD_OP_CANCEL 8'h26
`define ARBOP_CMD_CMP_CANCEL 8'h27
`define ARBOP_CMD_START 8'h50
`define ARBOP_CMD_BIT_CLR 5'h01
`define ARBOP_CMD_BIT_SET 5'h03

// Register indices (command code minus read base)
`define ARBOP_IDX_LAST_RW 6'h1c
`define ARBOP_IDX_PORT_CFG 6'h0d
`define ARBOP_IDX_CMP5 6'h1b
`define ARBOP_IDX_STEPS 6'h2c
`define ARBOP_SLOT_STEPS 5'h1d

// Pre-register slots
`define ARBOP_PRE_SLOTS 13
`define ARBOP_PRE_CMP 4'hb
`define ARBOP_PRE_STEPS 4'hc
`define ARBOP_PRE_LAST_OP 4'ha

// Settle time after a command or port write, in clocks
`define ARBOP_SETTLE_CYCLES 3'h4

// Reset values
`define ARBOP_RESET_WORD 32'h0000_0000
`define ARBOP_RESET_BYTE 8'h00

`endif

/* rtl/arbop_pkg.sv */
package arbop_pkg;

    // One host bus cycle, already synchronous to core_clk
    typedef struct packed {
        logic wr;
        logic rd;
        logic word_mode;
        logic [2:0] addr;
        logic [15:0] wdata;
    } arbop_bus_type;

    // Read-only values supplied by the axis motion core
    typedef struct packed {
        logic [27:0] cmd_pos_latch;
        logic [27:0] mech_pos_latch;
        logic [15:0] deflection_latch;
        logic [27:0] gp_latch;
        logic [21:0] extension_status;
        logic [17:0] error_irq_status;
        logic [19:0] event_irq_status;
        logic [27:0] residual_pulse_count;
        logic [22:0] zero_count_speed_monitor;
        logic [19:0] auto_rampdown_point;
        logic [30:0] circular_step_counter;
        logic [23:0] interp_status;
    } arbop_monitor_type;

    typedef enum logic {
        ARBOP_IDLE,
        ARBOP_SETTLE
    } arbop_settle_type;

endpackage : arbop_pkg

/* rtl/arbop_out_port.sv */
`timescale 1ns/1ps
`include "arbop_consts.svh"

module arbop_out_port (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Byte write and single-bit control
    input wire logic byte_wr,
    input wire logic [7:0] byte_data,
    input wire logic bit_wr,
    input wire logic [2:0] bit_sel,
    input wire logic bit_val,
    // Direction, 1 = output
    input wire logic [7:0] dir_out,
    // Terminals
    output logic [7:0] gp_port_terminals_o,
    output logic [7:0] gp_port_terminals_oe
);

    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] oe;
    } arbop_port_state_type;

    arbop_port_state_type st;
    arbop_port_state_type next_st;

    // The latch is kept whatever the direction, so a pin turned back to output resumes its old level
    always_comb begin
        next_st = st;
        next_st.oe = dir_out;
        if (byte_wr) begin
            next_st.latch = byte_data;
        end else if (bit_wr) begin
            next_st.latch[bit_sel] = bit_val;
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{latch: `ARBOP_RESET_BYTE, oe: `ARBOP_RESET_BYTE};
        end else begin
            st <= next_st;
        end
    end

    assign gp_port_terminals_o = st.latch;
    assign gp_port_terminals_oe = st.oe;

endmodule : arbop_out_port

/* dv/arbop_reg_bank_sva.sv */
`timescale 1ns/1ps
module arbop_reg_bank_sva #(
    parameter int NUM_AXES = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Host bus
    input wire arbop_pkg::arbop_bus_type bus,
    input wire logic [15:0] bus_rdata,
    input wire logic wait_request_n,
    // Motion core side
    input wire logic [NUM_AXES-1:0] op_done,
    input wire logic [NUM_AXES-1:0] cmp5_match,
    input wire arbop_pkg::arbop_monitor_type [NUM_AXES-1:0] monitor,
    input wire logic [NUM_AXES-1:0][31:0][31:0] axis_work,
    input wire logic [NUM_AXES-1:0][1:0] op_queue_fill,
    input wire logic [NUM_AXES-1:0][1:0] cmp_queue_fill,
    // Terminals
    input wire logic [7:0] gp_port_terminals_o,
    input wire logic [7:0] gp_port_terminals_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Helper views
    logic port_wr;
    logic [7:0] low_byte;
    logic [7:0] dir_cfg;
    logic [1:0] fill0;
    assign port_wr = bus.wr && (bus.addr == 3'h2);
    assign low_byte = bus.wdata[7:0];
    assign dir_cfg = axis_work[0][13][7:0];
    assign fill0 = op_queue_fill[0];

    AST_PORT_LATCH: assert property (
        port_wr && wait_request_n |=> gp_port_terminals_o == $past(low_byte))
        else $error("Port byte not latched");
    AST_OE_FOLLOW: assert property (
        gp_port_terminals_oe == $past(dir_cfg))
        else $error("Enable not following direction");
    AST_PORT_HOLD: assert property (
        !(bus.wr && (bus.addr == 3'h0 || bus.addr == 3'h2)) |=> $stable(gp_port_terminals_o))
        else $error("Port moved without a write");
    AST_SETTLE_LOW: assert property (
        port_wr && wait_request_n |=> !wait_request_n [*4] ##1 wait_request_n)
        else $error("Wait request not low for settling");
    AST_REFUSE: assert property (
        port_wr && !wait_request_n |=> $stable(gp_port_terminals_o))
        else $error("Port write taken in settle");
    AST_RESET_VALUES: assert property (
        $rose(rst_n) |-> axis_work == '0 && op_queue_fill == '0 && cmp_queue_fill == '0
            && gp_port_terminals_o == 8'h00 && bus_rdata == 16'h0000 && wait_request_n)
        else $error("State not cleared by reset");
    AST_RDATA_HOLD: assert property (
        !bus.rd |=> $stable(bus_rdata))
        else $error("Read data moved without a read");
    AST_WIDTH: assert property (
        axis_work[0][5][31:12] == 20'h00000 && axis_work[0][9][31:15] == 17'h00000
            && axis_work[0][28][31:19] == 13'h0000)
        else $error("Bits above register width set");
    AST_QUEUE_SHIFT: assert property (
        op_done[0] && fill0 >= 2'h2 && !bus.wr |=> fill0 == $past(fill0) - 2'h1)
        else $error("Queue not advanced");
endmodule : arbop_reg_bank_sva

bind arbop_reg_bank arbop_reg_bank_sva #(.NUM_AXES(NUM_AXES)) u_sva (
    .core_clk(core_clk), .rst_n(rst_n), .bus(bus), .bus_rdata(bus_rdata),
    .wait_request_n(wait_request_n), .op_done(op_done), .cmp5_match(cmp5_match),
    .monitor(monitor), .axis_work(axis_work), .op_queue_fill(op_queue_fill),
    .cmp_queue_fill(cmp_queue_fill), .gp_port_terminals_o(gp_port_terminals_o),
    .gp_port_terminals_oe(gp_port_terminals_oe)
);

/* dv/arbop_host_model.sv */
`timescale 1ns/1ps
module arbop_host_model (
    // Clock
    input wire logic core_clk,
    // Bus
    output arbop_pkg::arbop_bus_type bus,
    input wire logic [15:0] bus_rdata
);
    // Cleared to force a write into the settle window
    bit polite = 1'b1;

    initial bus = '0;

    // Word write; released data lines are scrambled
    task automatic put(input logic [2:0] addr, input logic [15:0] data);
        @(posedge core_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, word_mode: 1'b1, addr: addr, wdata: data};
        @(posedge core_clk);
        bus.wr <= 1'b0;
        bus.wdata <= ~data;
        if (polite && (addr == 3'h0 || addr == 3'h2)) begin
            repeat (4) @(posedge core_clk);
        end
        #1;
    endtask : put

    // Word read; data registers one edge after the strobe
    task automatic get(input logic [2:0] addr, output logic [15:0] data);
        @(posedge core_clk);
        bus.rd <= 1'b1;
        bus.addr <= addr;
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1 data = bus_rdata;
    endtask : get
endmodule : arbop_host_model

/* dv/axis_register_bank_out_port_tb.sv */
`timescale 1ns/1ps
module axis_register_bank_out_port_tb;
    // Design signals
    logic core_clk;
    logic rst_n;
    arbop_pkg::arbop_bus_type bus;
    logic [15:0] bus_rdata;
    logic wait_request_n;
    logic [3:0] op_done, cmp5_match;
    arbop_pkg::arbop_monitor_type [3:0] monitor;
    logic [3:0][31:0][31:0] axis_work;
    logic [3:0][1:0] op_queue_fill, cmp_queue_fill;
    logic [7:0] gp_port_terminals_o, gp_port_terminals_oe;
    // Bench state
    int error_cnt = 0;
    int compares = 0;
    int seed = 32'h3578f484;
    logic [31:0] exp_reg [4][46];

    arbop_reg_bank #(.NUM_AXES(4)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .bus(bus), .bus_rdata(bus_rdata),
        .wait_request_n(wait_request_n), .op_done(op_done), .cmp5_match(cmp5_match),
        .monitor(monitor), .axis_work(axis_work), .op_queue_fill(op_queue_fill),
        .cmp_queue_fill(cmp_queue_fill), .gp_port_terminals_o(gp_port_terminals_o),
        .gp_port_terminals_oe(gp_port_terminals_oe)
    );

    arbop_host_model host (.core_clk(core_clk), .bus(bus), .bus_rdata(bus_rdata));

    // 20 MHz reference clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Hang guard
    initial begin
        repeat (60000) @(posedge core_clk);
        error_cnt++;
        close_out();
    end

    task automatic close_out();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    // Compare and tally; x matches only an identical x
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Buffer, then command word with axis select
    task automatic wr_reg(input int a, input logic [7:0] code, input logic [31:0] v);
        host.put(3'h4, v[15:0]);
        host.put(3'h6, v[31:16]);
        host.put(3'h0, {8'(8'h01 << a), code});
    endtask : wr_reg

    task automatic rd_reg(input int a, input logic [7:0] code, output logic [31:0] v);
        host.put(3'h0, {8'(8'h01 << a), code});
        host.get(3'h4, v[15:0]);
        host.get(3'h6, v[31:16]);
    endtask : rd_reg

    // Implemented bits of each writable register
    function automatic logic [31:0] wmask(input int idx);
        int w;
        case (idx)
            5: w = 12;
            6, 44: w = 24;
            9, 10: w = 15;
            1, 2, 3, 4, 11, 21: w = 16;
            12, 13, 14, 15, 17, 18: w = 32;
            28: w = 19;
            default: w = 28;
        endcase
        return (w == 32) ? 32'hffff_ffff : ((32'h1 << w) - 32'h1);
    endfunction : wmask

    // Read-only values; unmapped indices read zero
    function automatic logic [31:0] ro_exp(input int a, input int idx);
        case (idx)
            29: return {4'h0, monitor[a].cmd_pos_latch};
            36: return {4'h0, monitor[a].residual_pulse_count};
            37: return {9'h000, monitor[a].zero_count_speed_monitor};
            38: return {12'h000, monitor[a].auto_rampdown_point};
            45: return {1'h0, monitor[a].circular_step_counter};
            default: return 32'h0000_0000;
        endcase
    endfunction : ro_exp

    initial begin
        int a, idx, k;
        int ro [6] = '{29, 36, 37, 38, 45, 40};
        logic [31:0] v, vb;
        logic [287:0] rnd;
        logic [7:0] dir;
        logic [15:0] pv;
        logic s;
        rst_n = 1'b0;
        op_done = '0;
        cmp5_match = '0;
        foreach (exp_reg[i, j]) exp_reg[i][j] = '0;
        // Random monitor values for the whole run
        for (a = 0; a < 4; a++) begin
            for (idx = 0; idx < 9; idx++) rnd[idx*32 +: 32] = $random(seed);
            monitor[a] = rnd[285:0];
        end
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        // Random writes, then read everything back
        repeat (60) begin
            a = $unsigned($random(seed)) % 4;
            idx = $unsigned($random(seed)) % 30;
            if (idx == 29) idx = 44;
            v = $random(seed);
            wr_reg(a, 8'(8'h90 + idx), v);
            exp_reg[a][idx] = v & wmask(idx);
        end
        for (a = 0; a < 4; a++) begin
            for (idx = 0; idx < 30; idx++) begin
                k = (idx == 29) ? 44 : idx;
                rd_reg(a, 8'(8'hd0 + k), v);
                check("reg", v, exp_reg[a][k]);
            end
            foreach (ro[i]) begin
                rd_reg(a, 8'(8'hd0 + ro[i]), v);
                check("ro", v, ro_exp(a, ro[i]));
            end
        end
        // Port: upper byte junk dropped
        dir = 8'($random(seed));
        pv = 16'($random(seed));
        wr_reg(0, 8'h9d, {24'h000000, dir});
        host.put(3'h2, pv);
        check("port", gp_port_terminals_o, pv[7:0]);
        check("oe", gp_port_terminals_oe, dir);
        // Single-bit set and clear
        for (idx = 0; idx < 8; idx++) begin
            s = 1'($random(seed));
            host.put(3'h0, {8'h01, 3'h0, s, 1'b1, 3'(idx)});
            pv[idx] = s;
            check("bit", gp_port_terminals_o, pv[7:0]);
        end
        // All inputs: latch kept
        wr_reg(0, 8'h9d, 32'h0000_0000);
        check("keep", gp_port_terminals_o, pv[7:0]);
        check("oe_in", gp_port_terminals_oe, 8'h00);
        // Port write while settling is dropped
        pv = 16'($random(seed));
        host.polite = 1'b0;
        host.put(3'h2, {8'h00, pv[7:0]});
        host.put(3'h2, {8'h00, ~pv[7:0]});
        host.polite = 1'b1;
        repeat (5) @(posedge core_clk);
        check("refuse", gp_port_terminals_o, pv[7:0]);
        // Two queued feeds, then a completion
        v = $random(seed);
        vb = $random(seed);
        wr_reg(0, 8'h80, v);
        host.put(3'h0, 16'h0150);
        check("work", axis_work[0][0], v & 32'h0fff_ffff);
        wr_reg(0, 8'h80, vb);
        host.put(3'h0, 16'h0150);
        check("fill", op_queue_fill[0], 32'h2);
        @(posedge core_clk);
        op_done <= 4'h1;
        @(posedge core_clk);
        op_done <= 4'h0;
        @(posedge core_clk);
        #1;
        check("shift", axis_work[0][0], vb & 32'h0fff_ffff);
        check("fill", op_queue_fill[0], 32'h1);
        // Comparator five pre write into empty queue
        v = $random(seed);
        wr_reg(0, 8'h8b, v);
        check("cmp5", axis_work[0][27], v & 32'h0fff_ffff);
        check("cfill", cmp_queue_fill[0], 32'h1);
        // Mid-run reset
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        #1;
        check("rst_port", gp_port_terminals_o, 32'h0);
        check("rst_work", axis_work[0][27], 32'h0);
        check("rst_fill", op_queue_fill[0], 32'h0);
        close_out();
    end
endmodule : axis_register_bank_out_port_tb
